// File: verilog/smc_pkg.sv
package smc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int           SMC_NUM_REGIONS = 4;
	localparam int           SMC_APB_AW      = 12;
	localparam logic [11:0]  SMC_REG_OFF [SMC_NUM_REGIONS] =
		'{12'h000, 12'h004, 12'h008, 12'h00c};
	localparam logic [31:0]  SMC_CFG_RST_LO  = 32'h00011f3f;
	localparam logic [31:0]  SMC_CFG_RST_HI  = 32'h00001f3f;
	// reserved bits keep their reset value
	localparam logic [31:0]  SMC_CFG_WMASK   = 32'hccff003f;

	// region configuration word, msb first
	typedef struct packed {
		logic [1:0] idle_cycles;
		logic [1:0] rsv_29;
		logic [1:0] strobe_delay;
		logic [1:0] rsv_25;
		logic       ext_hold_enable;
		logic       ext_hold_polarity;
		logic       muxed_bus_enable;
		logic       byte_lane_enable;
		logic [1:0] addr_hold_cycles;
		logic [1:0] bus_width_sel;
		logic [9:0] rsv_15;
		logic [5:0] base_wait_count;
	} smc_cfg_t;

	localparam logic [1:0]   SMC_WIDTH_8     = 2'h0;
	localparam logic [1:0]   SMC_WIDTH_16    = 2'h1;

	// ------------------------------------------------------------
	// internal bus request
	// ------------------------------------------------------------
	localparam logic [1:0]   SMC_SIZE_BYTE   = 2'h0;
	localparam logic [1:0]   SMC_SIZE_HALF   = 2'h1;
	localparam logic [1:0]   SMC_SIZE_WORD   = 2'h2;
	localparam int           SMC_SEL_MSB     = 26;
	localparam int           SMC_SEL_LSB     = 24;
	localparam int           SMC_OFFS_W      = 20;
	localparam int           SMC_LANE_W      = 8;

	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic [1:0]  size;
		logic [31:0] wdata;
	} smc_req_t;

	// ------------------------------------------------------------
	// external pins
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  region_select_n;
		logic        read_strobe_n;
		logic        upper_write_strobe_n;
		logic        lower_write_strobe_n;
		logic        upper_byte_select_n;
		logic        lower_byte_select_n;
		logic        addr_latch;
		logic [3:0]  addr_hi;
		logic [15:0] addr_lo;
		logic [15:0] ad_out;
		logic        ad_oe;
	} smc_ext_out_t;

	localparam smc_ext_out_t SMC_PINS_IDLE = '{
		region_select_n: 4'hf, read_strobe_n: 1'b1,
		upper_write_strobe_n: 1'b1, lower_write_strobe_n: 1'b1,
		upper_byte_select_n: 1'b1, lower_byte_select_n: 1'b1,
		addr_latch: 1'b0, addr_hi: 4'h0, addr_lo: 16'h0000,
		ad_out: 16'h0000, ad_oe: 1'b0};

	typedef enum logic [2:0] {
		SMC_IDLE, SMC_ADDR, SMC_ACC, SMC_GAP, SMC_DONE
	} smc_state_t;

endpackage

// File: verilog/smc_static_memory_controller.sv
// Function
// - four external regions of one megabyte, each with its own configuration
// - width and wait count of the accessed region apply to its access
// - four active-low region selects, only the accessed one low
// - read strobe low while reading external parts
// - upper write strobe low when writing the upper lane with 8-bit parts
// - lower write strobe low when writing the lower lane with 8-bit parts
// - upper and lower byte selects mark used lanes with 16-bit parts
// - active wait input stretches the access for as long as it stays active
// - in muxed mode address latch high while address is on shared lines
// - address bits 19:16 on own pins, sixteen shared address/data lines
// - strobe delay holds back read and write strobe fall by 0..3 cycles
// - bit 23 makes the controller honour or ignore the wait input
// - bit 22 picks wait input level: 0 low active, 1 high active
// - bit 21 picks separate (0) or multiplexed (1) address/data
// - bit 20 turns on byte lane write strobes for 8-bit parts
// - muxed address phase lasts address hold field plus one cycles
// - width field 00 selects 8-bit bus, 01 selects 16-bit bus
// - base wait field plus one cycles per access, reset 0x3f
// - regions 0,1 reset to 0x00011f3f, regions 2,3 to 0x00001f3f
// - address bits 26:24 pick region, bits 19:0 address within it
// - region selects change only on the rising clock edge
// - 8-bit bus splits halfwords in two and words in four beats
// - 8-bit parts on 16-bit bus: halfword both strobes, byte by a0
//
// The implementer's own choice: the APB slave port.
module smc_static_memory_controller
	import smc_pkg::*;
(
	input  logic                  pclk,
	input  logic                  presetn,
	input  logic                  psel,
	input  logic                  penable,
	input  logic                  pwrite,
	input  logic [SMC_APB_AW-1:0] paddr,
	input  logic [31:0]           pwdata,
	input  logic [3:0]            pstrb,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  logic                  mem_valid,
	input  smc_req_t              mem_req,
	output logic                  mem_ready,
	output logic [31:0]           mem_rdata,
	input  logic                  ext_hold_in,
	input  logic [15:0]           ad_in,
	output smc_ext_out_t          ext_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		smc_state_t                       st;
		logic [SMC_NUM_REGIONS-1:0][31:0] cfg;
		logic [1:0]                       region;
		logic [SMC_OFFS_W-1:0]            addr;
		logic                             wr;
		logic [1:0]                       size;
		logic [31:0]                      wdata;
		logic [31:0]                      rdata;
		logic [1:0]                       beat;
		logic [1:0]                       last;
		logic [5:0]                       cnt;
		logic [31:0]                      prdata;
		smc_ext_out_t                     pins;
	} smc_regs_t;

	smc_regs_t r;
	smc_regs_t r_nxt;
	smc_cfg_t  cur_c;

	assign cur_c     = smc_cfg_t'(r.cfg[r.region]);
	assign prdata    = r.prdata;
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign mem_ready = (r.st == SMC_DONE);
	assign mem_rdata = r.rdata;
	assign ext_out   = r.pins;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] beats_m1(input smc_cfg_t c, input logic [1:0] sz);
		if (c.bus_width_sel == SMC_WIDTH_16)
			return (sz == SMC_SIZE_WORD) ? 2'h1 : 2'h0;
		case (sz)
			SMC_SIZE_HALF: return 2'h1;
			SMC_SIZE_WORD: return 2'h3;
			default:       return 2'h0;
		endcase
	endfunction

	// pins follow the next state so every pin leaves a flip-flop
	function automatic smc_ext_out_t pins_of(input smc_regs_t s);
		smc_ext_out_t      p;
		smc_cfg_t          c;
		logic              w16;
		logic              act;
		logic              on;
		logic              lo;
		logic              hi;
		logic [SMC_OFFS_W-1:0] ba;
		logic [7:0]        b;
		p   = SMC_PINS_IDLE;
		c   = smc_cfg_t'(s.cfg[s.region]);
		w16 = (c.bus_width_sel == SMC_WIDTH_16);
		act = (s.st == SMC_ACC) || (s.st == SMC_ADDR);
		on  = (s.st == SMC_ACC) && (s.cnt >= {4'h0, c.strobe_delay});
		ba  = s.addr + SMC_OFFS_W'(w16 ? {s.beat, 1'b0} : {1'b0, s.beat});
		lo  = !w16 || (s.size != SMC_SIZE_BYTE) || !ba[0];
		hi  = w16 && ((s.size != SMC_SIZE_BYTE) || ba[0]);
		b   = s.wdata[SMC_LANE_W*s.beat +: SMC_LANE_W];
		if (act) begin
			p.region_select_n = ~(4'h1 << s.region);
			p.addr_hi         = ba[SMC_OFFS_W-1:16];
			p.addr_lo         = ba[15:0];
		end
		if (s.st == SMC_ADDR) begin
			p.addr_latch = 1'b1;
			p.ad_out     = ba[15:0];
			p.ad_oe      = 1'b1;
		end
		if (s.st == SMC_ACC) begin
			p.ad_oe = s.wr;
			if (!s.wr)
				p.ad_out = 16'h0000;
			else if (!w16)
				p.ad_out = {8'h00, b};
			else if (s.size == SMC_SIZE_BYTE)
				p.ad_out = {s.wdata[7:0], s.wdata[7:0]};
			else
				p.ad_out = s.wdata[2*SMC_LANE_W*s.beat[0] +: 2*SMC_LANE_W];
			p.read_strobe_n = !(on && !s.wr);
			if (c.byte_lane_enable) begin
				p.upper_write_strobe_n = !(on && s.wr && hi);
				p.lower_write_strobe_n = !(on && s.wr && lo);
			end else begin
				// 16-bit parts: lower strobe serves as the write enable
				p.lower_write_strobe_n = !(on && s.wr);
				p.upper_byte_select_n  = !hi;
				p.lower_byte_select_n  = !lo;
			end
		end
		return p;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		smc_cfg_t   nc;
		logic       hold_act;
		logic       w16;
		smc_state_t after;
		logic [2:0] sel;
		nc    = '0;
		r_nxt = r;
		sel   = mem_req.addr[SMC_SEL_MSB:SMC_SEL_LSB];
		w16   = (cur_c.bus_width_sel == SMC_WIDTH_16);
		// wait level compare against the programmed polarity
		hold_act = cur_c.ext_hold_enable &&
			(ext_hold_in == cur_c.ext_hold_polarity);
		if (r.beat == r.last)
			after = SMC_DONE;
		else
			after = cur_c.muxed_bus_enable ? SMC_ADDR : SMC_ACC;

		// register file, one aligned word each
		if (psel && !penable) begin
			r_nxt.prdata = 32'h00000000;
			for (int i = 0; i < SMC_NUM_REGIONS; i++)
				if (paddr == SMC_REG_OFF[i])
					r_nxt.prdata = r.cfg[i];
		end
		if (psel && penable && pwrite) begin
			for (int i = 0; i < SMC_NUM_REGIONS; i++)
				if (paddr == SMC_REG_OFF[i])
					for (int k = 0; k < 4; k++)
						if (pstrb[k])
							r_nxt.cfg[i][8*k +: 8] =
								(r.cfg[i][8*k +: 8] & ~SMC_CFG_WMASK[8*k +: 8]) |
								(pwdata[8*k +: 8] & SMC_CFG_WMASK[8*k +: 8]);
		end

		case (r.st)
			SMC_IDLE: begin
				if (mem_valid) begin
					r_nxt.addr  = mem_req.addr[SMC_OFFS_W-1:0];
					r_nxt.wr    = mem_req.write;
					r_nxt.size  = mem_req.size;
					r_nxt.wdata = mem_req.wdata;
					r_nxt.rdata = 32'h00000000;
					r_nxt.beat  = 2'h0;
					r_nxt.cnt   = 6'h00;
					// upper decode values map to no region: finish at once
					if (sel[2]) begin
						r_nxt.st = SMC_DONE;
					end else begin
						r_nxt.region = sel[1:0];
						nc           = smc_cfg_t'(r.cfg[sel[1:0]]);
						r_nxt.last   = beats_m1(nc, mem_req.size);
						r_nxt.st     = nc.muxed_bus_enable ? SMC_ADDR : SMC_ACC;
					end
				end
			end
			SMC_ADDR: begin
				if (r.cnt == {4'h0, cur_c.addr_hold_cycles}) begin
					r_nxt.cnt = 6'h00;
					r_nxt.st  = SMC_ACC;
				end else begin
					r_nxt.cnt = r.cnt + 6'h01;
				end
			end
			SMC_ACC: begin
				if (r.cnt != cur_c.base_wait_count) begin
					r_nxt.cnt = r.cnt + 6'h01;
				end else if (!hold_act) begin
					if (!r.wr) begin
						if (!w16)
							r_nxt.rdata[SMC_LANE_W*r.beat +: SMC_LANE_W] = ad_in[7:0];
						else if (r.size == SMC_SIZE_BYTE)
							r_nxt.rdata[7:0] = r.addr[0] ? ad_in[15:8] : ad_in[7:0];
						else
							r_nxt.rdata[2*SMC_LANE_W*r.beat[0] +: 2*SMC_LANE_W] = ad_in;
					end
					if (cur_c.idle_cycles != 2'h0) begin
						r_nxt.cnt = 6'h01;
						r_nxt.st  = SMC_GAP;
					end else begin
						r_nxt.cnt  = 6'h00;
						r_nxt.st   = after;
						r_nxt.beat = (after == SMC_DONE) ? r.beat : r.beat + 2'h1;
					end
				end
			end
			SMC_GAP: begin
				if (r.cnt == {4'h0, cur_c.idle_cycles}) begin
					r_nxt.cnt  = 6'h00;
					r_nxt.st   = after;
					r_nxt.beat = (after == SMC_DONE) ? r.beat : r.beat + 2'h1;
				end else begin
					r_nxt.cnt = r.cnt + 6'h01;
				end
			end
			SMC_DONE: r_nxt.st = SMC_IDLE;
			default:  r_nxt.st = SMC_IDLE;
		endcase
		r_nxt.pins = pins_of(r_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r        <= '0;
			r.st     <= SMC_IDLE;
			r.cfg    <= {SMC_CFG_RST_HI, SMC_CFG_RST_HI,
				SMC_CFG_RST_LO, SMC_CFG_RST_LO};
			r.pins   <= SMC_PINS_IDLE;
		end else begin
			r <= r_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_acc_start;
		r.st == SMC_ACC && r.cnt == 6'h00;
	endsequence

	sequence s_ale_start;
		$rose(ext_out.addr_latch) && cur_c.addr_hold_cycles == 2'h1;
	endsequence

	a_select_onehot: assert property (
		$onehot0(~ext_out.region_select_n))
		else $error("more than one region select low");

	a_select_decode: assert property (
		r.st == SMC_ACC |-> ext_out.region_select_n == ~(4'h1 << r.region))
		else $error("region select does not match region");

	a_read_strobe: assert property (
		!ext_out.read_strobe_n |-> r.st == SMC_ACC && !r.wr)
		else $error("read strobe low outside a read");

	a_strobe_delay: assert property (
		s_acc_start ##0 (!r.wr && cur_c.strobe_delay == 2'h1 &&
		cur_c.base_wait_count > 6'h01) |-> ext_out.read_strobe_n ##1 !ext_out.read_strobe_n)
		else $error("read strobe fall not delayed by one cycle");

	// with no idle gap the next beat restarts the count at zero
	a_wait_length: assert property (
		s_acc_start ##0 (cur_c.base_wait_count == 6'h02 && !cur_c.ext_hold_enable)
		|-> (r.st == SMC_ACC)[*3] ##1 (r.st != SMC_ACC || r.cnt == 6'h00))
		else $error("access length is not base wait plus one");

	a_hold_stretch: assert property (
		r.st == SMC_ACC && r.cnt == cur_c.base_wait_count && cur_c.ext_hold_enable &&
		ext_hold_in == cur_c.ext_hold_polarity |=> r.st == SMC_ACC)
		else $error("access ended while wait input active");

	a_hold_ignored: assert property (
		r.st == SMC_ACC && r.cnt == cur_c.base_wait_count && !cur_c.ext_hold_enable
		|=> r.st != SMC_ACC || r.cnt == 6'h00)
		else $error("disabled wait input stretched the access");

	a_addr_hold: assert property (
		s_ale_start |-> ext_out.addr_latch[*2] ##1 !ext_out.addr_latch)
		else $error("address phase not hold plus one cycles");

	a_idle_gap: assert property (
		$rose(r.st == SMC_GAP) && cur_c.idle_cycles == 2'h2
		|-> (ext_out.region_select_n == 4'hf)[*2] ##1 r.st != SMC_GAP)
		else $error("idle gap length wrong");

	a_word_split: assert property (
		s_acc_start ##0 (r.beat == 2'h0 && r.size == SMC_SIZE_WORD &&
		cur_c.bus_width_sel == SMC_WIDTH_8) |-> r.last == 2'h3)
		else $error("word on 8-bit bus not split in four");

	a_stall_busy: assert property (
		r.st == SMC_ACC || r.st == SMC_ADDR || r.st == SMC_GAP |-> !mem_ready)
		else $error("master released before the access finished");

	a_narrow_upper: assert property (
		r.st == SMC_ACC && cur_c.bus_width_sel == SMC_WIDTH_8
		|-> ext_out.upper_write_strobe_n)
		else $error("upper write strobe low on 8-bit bus");

	a_lower_strobe: assert property (
		!ext_out.lower_write_strobe_n |-> r.st == SMC_ACC && r.wr)
		else $error("lower write strobe low outside a write");

	a_upper_strobe: assert property (
		!ext_out.upper_write_strobe_n |-> r.st == SMC_ACC && r.wr &&
		cur_c.byte_lane_enable && cur_c.bus_width_sel == SMC_WIDTH_16)
		else $error("upper write strobe low without an upper lane");

	a_byte_lane_pick: assert property (
		r.st == SMC_ACC && r.wr && r.size == SMC_SIZE_BYTE &&
		r.cnt == cur_c.base_wait_count && cur_c.byte_lane_enable &&
		cur_c.bus_width_sel == SMC_WIDTH_16
		|-> ext_out.upper_write_strobe_n == !r.addr[0] &&
		ext_out.lower_write_strobe_n == r.addr[0])
		else $error("byte write strobe does not follow address bit 0");

	a_word_lanes: assert property (
		r.st == SMC_ACC && !cur_c.byte_lane_enable && r.size != SMC_SIZE_BYTE &&
		cur_c.bus_width_sel == SMC_WIDTH_16
		|-> !ext_out.upper_byte_select_n && !ext_out.lower_byte_select_n)
		else $error("byte selects not both low for a wide access");

	a_selects_quiet: assert property (
		cur_c.byte_lane_enable |-> ext_out.upper_byte_select_n && ext_out.lower_byte_select_n)
		else $error("byte select low with byte lane strobes enabled");

	a_latch_muxed: assert property (
		ext_out.addr_latch |-> cur_c.muxed_bus_enable && ext_out.ad_oe)
		else $error("address latch strobe on a separate bus");

	a_read_release: assert property (
		r.st == SMC_ACC && !r.wr |-> !ext_out.ad_oe)
		else $error("shared lines driven during a read");

	a_strobe_early: assert property (
		r.st == SMC_ACC && r.cnt < {4'h0, cur_c.strobe_delay} |-> ext_out.read_strobe_n &&
		ext_out.lower_write_strobe_n && ext_out.upper_write_strobe_n)
		else $error("strobe fell before the strobe delay ran out");

	a_half_split: assert property (
		s_acc_start ##0 (r.beat == 2'h0 && r.size == SMC_SIZE_HALF &&
		cur_c.bus_width_sel == SMC_WIDTH_8) |-> r.last == 2'h1)
		else $error("halfword on 8-bit bus not split in two");

	a_unmapped_done: assert property (
		r.st == SMC_IDLE && mem_valid && mem_req.addr[SMC_SEL_MSB]
		|=> r.st == SMC_DONE && ext_out.region_select_n == 4'hf)
		else $error("unmapped access reached the pins");

	a_ready_pulse: assert property (
		mem_ready |=> !mem_ready)
		else $error("ready held past one cycle");

endmodule

// File: sim/smc_ext_mem_model.sv
module smc_ext_mem_model
	import smc_pkg::*;
(
	input  logic         pclk,
	input  smc_ext_out_t ext_out,
	input  logic         wide16,
	input  logic         parts8,
	input  logic         muxed,
	input  logic         slow,
	input  logic         hold_pol,
	output logic         ext_hold_in,
	output logic [15:0]  ad_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:4095];
	logic [15:0] lat;
	logic [15:0] last = 16'h0000;
	logic [11:0] a;
	logic [11:0] la;
	logic [11:0] ua;
	logic        sel;
	logic        rd;
	int          hcnt = 0;
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
	// ------------------------------------------------------------
	// address latch and lanes
	// ------------------------------------------------------------
	always @(posedge pclk) if (ext_out.addr_latch) lat <= ext_out.ad_out;
	assign a   = muxed ? lat[11:0] : ext_out.addr_lo[11:0];
	assign la  = wide16 ? {a[11:1], 1'b0} : a;
	assign ua  = {a[11:1], 1'b1};
	assign sel = ~&ext_out.region_select_n;
	assign rd  = sel && !ext_out.read_strobe_n;
	always @(posedge pclk) begin
		if (sel && !ext_out.lower_write_strobe_n && (parts8 || !ext_out.lower_byte_select_n))
			mem[la] <= ext_out.ad_out[7:0];
		if (sel && wide16 && (parts8 ? !ext_out.upper_write_strobe_n :
			!ext_out.lower_write_strobe_n && !ext_out.upper_byte_select_n))
			mem[ua] <= ext_out.ad_out[15:8];
		last <= ad_in;
	end
	// undriven lanes flip every cycle so stale data never looks valid
	assign ad_in = rd ? {wide16 ? mem[ua] : ~last[15:8], mem[la]} : ~last;
	// ------------------------------------------------------------
	// slow part: stretches the first three cycles of each select
	// ------------------------------------------------------------
	always @(posedge pclk) hcnt <= sel ? hcnt + 1 : 0;
	assign ext_hold_in = (slow && sel && hcnt < 3) ? hold_pol : !hold_pol;
endmodule

// File: sim/smc_static_memory_controller_tb.sv
module smc_static_memory_controller_tb
	import smc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic         mem_valid, mem_ready, ext_hold_in, cur_wr, fs;
	logic         wide16, parts8, muxed, slow, hold_pol;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, mem_rdata, rd, ad, wd;
	logic [3:0]   pstrb, sel_x;
	logic [15:0]  ad_in;
	smc_req_t     mem_req;
	smc_ext_out_t ext_out;
	smc_cfg_t     cf;
	int           failures, comparisons, cyc, sc;
	integer       seed;

	smc_static_memory_controller dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .mem_valid, .mem_req, .mem_ready,
		.mem_rdata, .ext_hold_in, .ad_in, .ext_out);
	smc_ext_mem_model part (.pclk, .ext_out, .wide16, .parts8, .muxed, .slow, .hold_pol,
		.ext_hold_in, .ad_in);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic setup(input int r);
		apb(1, 12'(4 * r), cf);
		wide16 <= cf.bus_width_sel == SMC_WIDTH_16;
		parts8 <= cf.byte_lane_enable;
		muxed <= cf.muxed_bus_enable;
	endtask

	// cyc counts falling edges up to the one that sees ready
	task automatic mop(input logic [31:0] a, input logic w, input logic [1:0] sz,
		input logic [31:0] d);
		@(posedge pclk);
		mem_valid <= 1;
		mem_req <= '{addr: a, write: w, size: sz, wdata: d};
		cur_wr = w;
		cyc = 0;
		do begin
			@(negedge pclk);
			cyc++;
		end while (mem_ready !== 1'b1);
		rd = mem_rdata;
		@(posedge pclk);
		mem_valid <= 0;
	endtask

	function automatic int exp_cyc(input logic [1:0] sz, input int hold);
		int beats;
		beats = wide16 ? (sz == SMC_SIZE_WORD ? 2 : 1) : 1 << sz;
		return beats * ((cf.muxed_bus_enable ? cf.addr_hold_cycles + 1 : 0)
			+ cf.base_wait_count + 1 + hold + cf.idle_cycles) + 2;
	endfunction

	// ------------------------------------------------------------
	// pin monitor
	// ------------------------------------------------------------
	always @(negedge pclk) begin
		if (presetn && ~&ext_out.region_select_n) begin
			chk(ext_out.region_select_n, sel_x);
			chk(ext_out.addr_hi, ad[19:16]);
			chk(ext_out.addr_lo[15:2], ad[15:2]);
			chk(ext_out.ad_oe, cur_wr || ext_out.addr_latch);
			if (cur_wr)
				chk(ext_out.read_strobe_n, 1'b1);
			else
				chk({ext_out.upper_write_strobe_n, ext_out.lower_write_strobe_n}, 2'h3);
			if (parts8)
				chk({ext_out.upper_byte_select_n, ext_out.lower_byte_select_n}, 2'h3);
			if (!wide16)
				chk(ext_out.upper_write_strobe_n, 1'b1);
			if (ext_out.addr_latch)
				chk({ext_out.ad_oe, ext_out.ad_out[15:2]}, {1'b1, ad[15:2]});
			if (!fs && !(ext_out.read_strobe_n && ext_out.lower_write_strobe_n
				&& ext_out.upper_write_strobe_n)) begin
				chk(sc, (muxed ? cf.addr_hold_cycles + 1 : 0) + cf.strobe_delay);
				fs = 1;
			end
			sc++;
		end else begin
			sc = 0;
			fs = 0;
		end
	end

	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		close_out;
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		seed = 32'he469;
		{psel, penable, pwrite, mem_valid, slow, hold_pol, cur_wr, fs} = '0;
		{wide16, parts8, muxed, paddr, pwdata, ad} = '0;
		{sc, failures, comparisons} = '0;
		pstrb = 4'hf;
		mem_req = '0;
		cf = '0;
		sel_x = 4'hf;
		presetn = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		for (int r = 0; r < 4; r++) begin
			wd = r < 2 ? SMC_CFG_RST_LO : SMC_CFG_RST_HI;
			apb(0, 12'(4 * r), 0);
			chk(rd, wd);
			chk({pready, pslverr}, 2'h2);
			apb(1, 12'(4 * r), '1);
			apb(0, 12'(4 * r), 0);
			chk(rd, wd | SMC_CFG_WMASK);
		end
		apb(1, 12'h010, $random(seed));
		apb(0, 12'h010, 0);
		chk(rd, 0);
		$display("test registers done");
		for (int n = 0; n < 16; n++) begin
			cf = smc_cfg_t'(32'($random(seed)) & 32'hcc1f0000);
			cf.muxed_bus_enable = n[0];
			cf.base_wait_count = 6'(cf.strobe_delay + 1 + n % 3);
			sel_x = ~(4'h1 << (n >> 2));
			setup(n >> 2);
			for (int sz = 0; sz < 3; sz++) begin
				ad = {5'h0, 3'(n >> 2), 4'h0, 4'($random(seed)), 8'h0, 8'($random(seed))};
				ad[1:0] = ad[1:0] & ~2'((1 << sz) - 1);
				wd = $random(seed) & ~(32'hffffffff << (8 << sz));
				mop(ad, 1, 2'(sz), wd);
				chk(cyc, exp_cyc(2'(sz), 0));
				mop(ad, 0, 2'(sz), 0);
				chk(cyc, exp_cyc(2'(sz), 0));
				chk(rd, wd);
			end
		end
		$display("test accesses done");
		cf = '0;
		cf.base_wait_count = 6'h1;
		cf.bus_width_sel = SMC_WIDTH_16;
		sel_x = 4'he;
		ad = 32'h00000020;
		slow <= 1;
		for (int k = 0; k < 4; k++) begin
			cf.ext_hold_enable = k[0];
			cf.ext_hold_polarity = k[1];
			hold_pol <= k[1];
			setup(0);
			mop(ad, 0, SMC_SIZE_BYTE, 0);
			chk(cyc, exp_cyc(SMC_SIZE_BYTE, k[0] ? 2 : 0));
		end
		slow <= 0;
		$display("test wait input done");
		sel_x = 4'hf;
		mop(32'h04000000, 0, SMC_SIZE_WORD, 0);
		chk(cyc, 2);
		chk(rd, 0);
		$display("test unmapped region done");
		close_out;
	end
endmodule
